// *** src/fprs_pkg.sv ***
// fprs_pkg: shared types and constants for the flash programming command responder
// assumes one 100 MHz core clock and a frame decoder/encoder outside this block
package fprs_pkg;

  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned BLK_W      = 8;
  localparam int unsigned FRAME_LEN  = 256;
  localparam int unsigned CNT_W      = 9;

  // command codes: arbitrary values, the frame decoder maps the real ones
  localparam logic [7:0] CMD_RESET   = 8'h00;
  localparam logic [7:0] CMD_STATUS  = 8'h70;
  localparam logic [7:0] CMD_READ    = 8'h50;

  // status codes
  localparam logic [7:0] ST_CMD_ERR  = 8'h04;
  localparam logic [7:0] ST_PARAM    = 8'h05;
  localparam logic [7:0] ST_ACK      = 8'h06;
  localparam logic [7:0] ST_SUM_ERR  = 8'h07;
  localparam logic [7:0] ST_VERIFY   = 8'h0f;
  localparam logic [7:0] ST_PROTECT  = 8'h10;
  localparam logic [7:0] ST_NACK     = 8'h15;
  localparam logic [7:0] ST_ERASE    = 8'h1a;
  localparam logic [7:0] ST_MARGIN   = 8'h1b;
  localparam logic [7:0] ST_WRITE    = 8'h1c;

  // frame terminators
  localparam logic [7:0] TERM_ETB    = 8'h17;
  localparam logic [7:0] TERM_ETX    = 8'h03;
  // length field: zero stands for a full 256-byte payload
  localparam logic [7:0] LEN_FULL    = 8'h00;
  localparam logic [7:0] ST_RESET_VAL = 8'h06;

  typedef struct packed {
    logic              valid;
    logic [7:0]        code;
    logic              sum_ok;
    logic              len_ok;
    logic              etx_ok;
    logic [ADDR_W-1:0] start_addr;
    logic [ADDR_W-1:0] end_addr;
  } fprs_cmd_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } fprs_stat_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } fprs_byte_s;

  typedef struct packed {
    logic write_err;
    logic erase_margin_error;
    logic verify_margin_error;
    logic verify_err;
  } fprs_err_s;

endpackage

// *** src/fprs_rom.sv ***
// fprs_rom: flash array image with one write port and a registered read port
// assumes writes come from the programming engine on the same clock
module fprs_rom
  import fprs_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              wr_en_in,
  input  wire logic [ADDR_W-1:0] wr_addr_in,
  input  wire logic [7:0]        wr_data_in,
  input  wire logic              rd_en_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic      [7:0]        rd_data_out
);

  logic [7:0] mem [2**ADDR_W];

  // read data holds while rd_en is low, so the caller may stall
  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
    if (rd_en_in)
    begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule

// *** src/fprs_core.sv ***
// fprs_core: device-side responder for the read, status and reset commands
// assumes decoded command frames, programmer replies and error levels on CORE_CLK_IN

// Summary of operation
// - read answers 06H, or refuses with 05H, 07H, 10H or 15H
// - status codes 04H,1CH,1AH,1BH,0FH
// - reset acknowledge means link synchronised
// - NACK on bad frame, or on any command but status with a good checksum while busy
module fprs_core
(
  input  wire logic               CORE_CLK_IN,
  input  wire logic               RST_N_IN,
  input  wire fprs_pkg::fprs_cmd_s CMD_IN,
  input  wire fprs_pkg::fprs_stat_s REPLY_IN,
  input  wire fprs_pkg::fprs_err_s ERR_IN,
  input  wire logic               READ_PROTECT_IN,
  input  wire logic               MEM_WR_EN_IN,
  input  wire logic [fprs_pkg::ADDR_W-1:0] MEM_WR_ADDR_IN,
  input  wire logic [7:0]         MEM_WR_DATA_IN,
  input  wire logic               TX_READY_IN,
  output fprs_pkg::fprs_stat_s    STAT_OUT,
  output fprs_pkg::fprs_byte_s    TX_OUT,
  output logic                    BUSY_HANDSHAKE_OUT
);
  import fprs_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_LEN,
    S_RDREQ,
    S_LOAD,
    S_SEND,
    S_TERM,
    S_WAITACK
  } fprs_state_e;

  fprs_state_e        state_q, state_d;
  fprs_stat_s         stat_q, stat_d;
  fprs_byte_s         tx_q, tx_d;
  logic [7:0]         last_stat_q, last_stat_d;
  logic [ADDR_W-1:0]  addr_q, addr_d;
  logic [ADDR_W-1:0]  end_q, end_d;
  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic               rd_en;
  logic [7:0]         rd_data;

  function automatic logic [ADDR_W-BLK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
    blk_of = a[ADDR_W-1:BLK_W];
  endfunction

  // sticky op errors win over the stored reply, most severe first
  function automatic logic [7:0] status_code(input fprs_err_s e, input logic [7:0] last);
    if (e.write_err)
      status_code = ST_WRITE;
    else if (e.erase_margin_error)
      status_code = ST_ERASE;
    else if (e.verify_margin_error)
      status_code = ST_MARGIN;
    else if (e.verify_err)
      status_code = ST_VERIFY;
    else
      status_code = last;
  endfunction

  fprs_rom u_rom
  (
    .clk_in      (CORE_CLK_IN),
    .wr_en_in    (MEM_WR_EN_IN),
    .wr_addr_in  (MEM_WR_ADDR_IN),
    .wr_data_in  (MEM_WR_DATA_IN),
    .rd_en_in    (rd_en),
    .rd_addr_in  (addr_q),
    .rd_data_out (rd_data)
  );

  always_comb
  begin
    state_d     = state_q;
    stat_d      = '0;
    tx_d        = tx_q;
    last_stat_d = last_stat_q;
    addr_d      = addr_q;
    end_d       = end_q;
    cnt_d       = cnt_q;
    rd_en       = 1'b0;

    if (CMD_IN.valid)
    begin
      stat_d.valid = 1'b1;
      if (!CMD_IN.len_ok || !CMD_IN.etx_ok)
      begin
        stat_d.code = ST_NACK;
      end
      else if (!CMD_IN.sum_ok)
      begin
        stat_d.code = ST_SUM_ERR;
      end
      else if (CMD_IN.code == CMD_STATUS)
      begin
        stat_d.code = status_code(ERR_IN, last_stat_q);
      end
      else if (state_q != S_IDLE)
      begin
        // anything but a status query during a transfer is refused
        stat_d.code = ST_NACK;
      end
      else if (CMD_IN.code == CMD_RESET)
      begin
        stat_d.code = ST_ACK;
      end
      else if (CMD_IN.code == CMD_READ)
      begin
        if (CMD_IN.start_addr[BLK_W-1:0] != '0 || CMD_IN.end_addr[BLK_W-1:0] != '1
            || blk_of(CMD_IN.end_addr) < blk_of(CMD_IN.start_addr))
        begin
          stat_d.code = ST_PARAM;
        end
        else if (READ_PROTECT_IN)
        begin
          stat_d.code = ST_PROTECT;
        end
        else
        begin
          stat_d.code = ST_ACK;
          addr_d      = CMD_IN.start_addr;
          end_d       = CMD_IN.end_addr;
          state_d     = S_LEN;
        end
      end
      else
      begin
        stat_d.code = ST_CMD_ERR;
      end
      // a good status query only reports; one with a frame or checksum error stores its error code
      if (CMD_IN.code != CMD_STATUS || !CMD_IN.len_ok || !CMD_IN.etx_ok || !CMD_IN.sum_ok)
      begin
        last_stat_d = stat_d.code;
      end
    end

    case (state_q)
      S_IDLE:
      begin
        tx_d = '0;
      end
      S_LEN:
      begin
        if (!tx_q.valid)
        begin
          tx_d    = '{valid: 1'b1, data: LEN_FULL, last: 1'b0};
          cnt_d   = '0;
        end
        else if (TX_READY_IN)
        begin
          tx_d    = '0;
          state_d = S_RDREQ;
        end
      end
      S_RDREQ:
      begin
        rd_en   = 1'b1;
        state_d = S_LOAD;
      end
      S_LOAD:
      begin
        tx_d    = '{valid: 1'b1, data: rd_data, last: 1'b0};
        state_d = S_SEND;
      end
      S_SEND:
      begin
        if (TX_READY_IN)
        begin
          tx_d   = '0;
          cnt_d  = cnt_q + 1'b1;
          if (cnt_q == CNT_W'(FRAME_LEN - 1))
          begin
            state_d = S_TERM;
          end
          else
          begin
            addr_d  = addr_q + 1'b1;
            state_d = S_RDREQ;
          end
        end
      end
      S_TERM:
      begin
        if (!tx_q.valid)
        begin
          // intermediate frames close with ETB, the final one with ETX
          tx_d.valid = 1'b1;
          tx_d.last  = 1'b1;
          tx_d.data  = (addr_q == end_q) ? TERM_ETX : TERM_ETB;
        end
        else if (TX_READY_IN)
        begin
          tx_d    = '0;
          state_d = S_WAITACK;
        end
      end
      S_WAITACK:
      begin
        if (REPLY_IN.valid)
        begin
          // a NACK or any other code aborts; the programmer reports the frame error
          if (REPLY_IN.code != ST_ACK)
          begin
            state_d = S_IDLE;
          end
          else if (addr_q == end_q)
          begin
            state_d = S_IDLE;
          end
          else
          begin
            addr_d  = addr_q + 1'b1;
            state_d = S_LEN;
          end
        end
      end
      default:
      begin
        state_d = S_IDLE;
        tx_d    = '0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      state_q     <= S_IDLE;
      stat_q      <= '0;
      tx_q        <= '0;
      last_stat_q <= ST_RESET_VAL;
      addr_q      <= '0;
      end_q       <= '0;
      cnt_q       <= '0;
    end
    else
    begin
      state_q     <= state_d;
      stat_q      <= stat_d;
      tx_q        <= tx_d;
      last_stat_q <= last_stat_d;
      addr_q      <= addr_d;
      end_q       <= end_d;
      cnt_q       <= cnt_d;
    end
  end

  assign STAT_OUT           = stat_q;
  assign TX_OUT             = tx_q;
  // busy stays high for the whole read transfer, so status polls see it
  assign BUSY_HANDSHAKE_OUT = (state_q != S_IDLE);

endmodule

// *** verif/fprs_core_monitor.sv ***
// fprs_core_monitor: port-level checks of the command responder
// assumes only the top ports are seen; attached by the bind at the foot
module fprs_core_monitor
  import fprs_pkg::*;
(
  input wire logic       CORE_CLK_IN,
  input wire logic       RST_N_IN,
  input wire fprs_cmd_s  CMD_IN,
  input wire fprs_err_s  ERR_IN,
  input wire logic       TX_READY_IN,
  input wire fprs_stat_s STAT_OUT,
  input wire fprs_byte_s TX_OUT,
  input wire logic       BUSY_HANDSHAKE_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic frm_ok = CMD_IN.len_ok && CMD_IN.etx_ok;
  wire logic all_ok = frm_ok && CMD_IN.sum_ok;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_stat_answer: assert property (CMD_IN.valid |=> STAT_OUT.valid)
    else $error("missing status");
  a_stat_cause: assert property (STAT_OUT.valid |-> $past(CMD_IN.valid))
    else $error("status without command");
  a_frame_nack: assert property (CMD_IN.valid && !frm_ok |=> STAT_OUT.code == ST_NACK)
    else $error("bad frame not refused");
  a_sum_err: assert property (CMD_IN.valid && frm_ok && !CMD_IN.sum_ok
    |=> STAT_OUT.code == ST_SUM_ERR)
    else $error("checksum code wrong");
  a_busy_nack: assert property (CMD_IN.valid && all_ok && BUSY_HANDSHAKE_OUT
    && CMD_IN.code != CMD_STATUS |=> STAT_OUT.code == ST_NACK)
    else $error("busy command not refused");
  a_write_first: assert property (CMD_IN.valid && all_ok && CMD_IN.code == CMD_STATUS
    && ERR_IN.write_err |=> STAT_OUT.code == ST_WRITE)
    else $error("write error not first");
  a_tx_hold: assert property (TX_OUT.valid && !TX_READY_IN
    |=> TX_OUT.valid && $stable(TX_OUT.data))
    else $error("byte dropped in stall");
  a_len_first: assert property ($rose(BUSY_HANDSHAKE_OUT)
    |-> ##1 TX_OUT.valid && TX_OUT.data == LEN_FULL)
    else $error("frame not opened by length");
  a_last_term: assert property (TX_OUT.valid && TX_OUT.last
    |-> TX_OUT.data == TERM_ETX || TX_OUT.data == TERM_ETB)
    else $error("terminator flag on data byte");
endmodule
bind fprs_core fprs_core_monitor fprs_core_monitor_inst (
  .CORE_CLK_IN        (CORE_CLK_IN),
  .RST_N_IN           (RST_N_IN),
  .CMD_IN             (CMD_IN),
  .ERR_IN             (ERR_IN),
  .TX_READY_IN        (TX_READY_IN),
  .STAT_OUT           (STAT_OUT),
  .TX_OUT             (TX_OUT),
  .BUSY_HANDSHAKE_OUT (BUSY_HANDSHAKE_OUT)
);

// *** verif/fprs_prog_model.sv ***
// fprs_prog_model: programmer side of the read data stream
// assumes the core's byte handshake; one reply after each 258-byte frame
module fprs_prog_model
  import fprs_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       nack_in,
  input  wire fprs_byte_s tx_in,
  output logic            ready_out,
  output fprs_stat_s      reply_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  logic       rx_last[$];
  logic [8:0] cnt_q = '0;
  logic [1:0] gap_q = '0;
  initial ready_out = 1'b0;
  initial reply_out = '0;
  // ready toggles so every data byte meets a one-cycle stall; the terminator is taken at once
  always @(posedge clk_in)
  begin
    ready_out <= ~ready_out;
    if (gap_q != 2'h0)
      gap_q <= gap_q - 1'b1;
    if (tx_in.valid && ready_out)
    begin
      rx_q.push_back(tx_in.data);
      rx_last.push_back(tx_in.last);
      cnt_q <= (cnt_q == 9'd257) ? '0 : cnt_q + 1'b1;
      if (cnt_q == 9'd257)
        gap_q <= 2'h3;
    end
    if (gap_q == 2'h1)
      reply_out <= '{1'b1, nack_in ? ST_NACK : ST_ACK};
    else
      reply_out <= '{1'b0, ~reply_out.code};
  end
endmodule

// *** verif/fprs_core_tb.sv ***
// fprs_core_tb: scenario bench for the command responder
// assumes the programmer model answers the data stream
module fprs_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fprs_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  fprs_cmd_s   cmd = '0;
  fprs_err_s   err = '0;
  logic        prot = 1'b0;
  logic        we = 1'b0;
  logic        nack = 1'b0;
  logic [11:0] wa = '0;
  logic [7:0]  wd = '0;
  logic        rdy;
  logic        busy;
  fprs_stat_s  rep;
  fprs_stat_s  stat;
  fprs_byte_s  tx;
  int          fails = 0;
  int          check_count = 0;
  // idle cycles the programmer leaves after loading memory, before the read command
  localparam int CMD_GAP = 4;
  always #5 clk = ~clk;
  fprs_core fprs_core_inst (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CMD_IN(cmd), .REPLY_IN(rep),
    .ERR_IN(err), .READ_PROTECT_IN(prot), .MEM_WR_EN_IN(we), .MEM_WR_ADDR_IN(wa),
    .MEM_WR_DATA_IN(wd), .TX_READY_IN(rdy), .STAT_OUT(stat), .TX_OUT(tx),
    .BUSY_HANDSHAKE_OUT(busy));
  fprs_prog_model fprs_prog_model_inst (.clk_in(clk), .nack_in(nack), .tx_in(tx),
    .ready_out(rdy), .reply_out(rep));
  function automatic logic [7:0] pat(input int a);
    return 8'(a) ^ 8'(a >> 8) ^ 8'h5a;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic q(input logic [7:0] c, input logic [11:0] s, input logic [11:0] e,
                   input logic [2:0] ok, input logic [7:0] x);
    @(posedge clk);
    cmd <= '{1'b1, c, ok[2], ok[1], ok[0], s, e};
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1 chk(16'({stat.valid, stat.code}), 16'({1'b1, x}));
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 8000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    // a stuck transfer counts as a frame time-out
    if (busy !== 1'b0)
    begin
      fails++;
      final_report();
    end
  endtask
  task automatic t_status;
    logic [3:0] e [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
    logic [7:0] x [5] = '{ST_ACK, ST_VERIFY, ST_MARGIN, ST_ERASE, ST_WRITE};
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      err <= fprs_err_s'(e[i]);
      q(CMD_STATUS, '0, '0, 3'h7, x[i]);
    end
    @(posedge clk);
    err <= '0;
  endtask
  task automatic t_refuse;
    q(CMD_READ, 12'h010, 12'h0ff, 3'h7, ST_PARAM);
    q(CMD_READ, 12'h100, 12'h0ff, 3'h7, ST_PARAM);
    q(CMD_READ, 12'h000, 12'h0ff, 3'h3, ST_SUM_ERR);
    q(CMD_STATUS, '0, '0, 3'h5, ST_NACK);
    q(CMD_RESET, '0, '0, 3'h6, ST_NACK);
    q(8'h33, '0, '0, 3'h7, ST_CMD_ERR);
    @(posedge clk);
    prot <= 1'b1;
    q(CMD_READ, 12'h000, 12'h1ff, 3'h7, ST_PROTECT);
    @(posedge clk);
    prot <= 1'b0;
    q(CMD_STATUS, '0, '0, 3'h7, ST_PROTECT);
    q(CMD_RESET, '0, '0, 3'h7, ST_ACK);
    q(CMD_STATUS, '0, '0, 3'h7, ST_ACK);
  endtask
  task automatic t_sync;
    logic [7:0] got;
    int         tries;
    tries = 0;
    got   = ST_NACK;
    // first attempt is sent without its end marker, so one retry is needed
    while (got != ST_ACK && tries < 16)
    begin
      wait_idle();
      @(posedge clk);
      cmd <= '{1'b1, CMD_RESET, 1'b1, 1'b1, tries != 0, 12'h000, 12'h000};
      @(posedge clk);
      cmd.valid <= 1'b0;
      #1 got = stat.code;
      wait_idle();
      tries++;
    end
    chk(16'(tries), 16'd2);
    q(CMD_STATUS, '0, '0, 3'h7, ST_ACK);
  endtask
  task automatic t_read;
    for (int a = 0; a < 512; a++)
    begin
      @(posedge clk);
      we <= 1'b1;
      wa <= 12'(a);
      wd <= pat(a);
    end
    @(posedge clk);
    we <= 1'b0;
    repeat (CMD_GAP) @(posedge clk);
    q(CMD_READ, 12'h000, 12'h1ff, 3'h7, ST_ACK);
    chk(16'(busy), 16'h1);
    q(CMD_READ, 12'h000, 12'h0ff, 3'h7, ST_NACK);
    q(CMD_STATUS, '0, '0, 3'h7, ST_NACK);
    wait_idle();
    chk(16'(fprs_prog_model_inst.rx_q.size()), 16'd516);
    for (int f = 0; f < 2; f++)
    begin
      chk(16'(fprs_prog_model_inst.rx_q[f*258]), 16'(LEN_FULL));
      for (int i = 0; i < 256; i++)
        chk(16'(fprs_prog_model_inst.rx_q[f*258+1+i]), 16'(pat(f*256+i)));
      chk(16'(fprs_prog_model_inst.rx_q[f*258+257]), 16'(f ? TERM_ETX : TERM_ETB));
      chk(16'(fprs_prog_model_inst.rx_last[f*258+257]), 16'h1);
      chk(16'(fprs_prog_model_inst.rx_last[f*258+256]), 16'h0);
    end
  endtask
  task automatic t_nack;
    @(posedge clk);
    nack <= 1'b1;
    fprs_prog_model_inst.rx_q.delete();
    fprs_prog_model_inst.rx_last.delete();
    q(CMD_READ, 12'h000, 12'h1ff, 3'h7, ST_ACK);
    wait_idle();
    chk(16'(fprs_prog_model_inst.rx_q.size()), 16'd258);
    @(posedge clk);
    nack <= 1'b0;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_status();
    t_refuse();
    t_sync();
    t_read();
    t_nack();
    final_report();
  end
endmodule
